/* File: design/host_port_consts.svh */
// Functional notes
// - Ten-bit address, bit 0 least significant
// - Data bus undriven when deselected or reset
// - Bit-order strap: low MSB first, high LSB
// - High scrambler strap disables x43+1 scrambling
// - High encapsulation strap selects X.86, low HDLC
// - Software mode uses register control bits
// - SPI instruction on o_spi_mosi, then zeros (no address), read data on data bit 1
// - Master-out changes on phase-selected clock edge
// - Master-in sampled on opposite clock edge
// - Interface select: strobes, data strobe, SPI
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH
`define HP_ADDR_W 10
`define HP_DATA_W 8
`define HP_SEL_RW 2'h0
`define HP_SEL_DS 2'h1
`define HP_SEL_SPI 2'h2
`define HP_SEL_RSV 2'h3
`define HP_BIT_ORDER 0
`define HP_SCRAMBLE_DIS 1
`define HP_ENCAP 2
`define HP_SPI_INSTR 8'h03
`define HP_SPI_DIV 4'h4
`define HP_SPI_BYTES 10'h010
`endif

/* File: design/host_port_pkg.sv */
`default_nettype none
package host_port_pkg;
  typedef struct packed {
    logic bit_order_lsb;
    logic scrambler_off;
    logic laps_encap;
  } line_cfg_s;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE = 2'b10
  } spi_state_e;
endpackage
`default_nettype wire

/* File: design/spi_shifter.sv */
`include "host_port_consts.svh"
`default_nettype none
module spi_shifter (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Edge strobes
  input wire logic i_phase_edge,
  input wire logic i_sample_edge,
  // Shift data
  input wire logic i_load,
  input wire logic [7:0] i_load_byte,
  input wire logic i_miso,
  output logic o_mosi,
  output logic [7:0] o_rx_byte
);
  import host_port_pkg::*;

  typedef struct packed {
    logic [7:0] tx;
    logic [7:0] rx;
    logic mosi;
  } shift_s;

  shift_s r;
  shift_s next_r;

  always_comb begin
    next_r = r;
    if (i_load) begin
      next_r.tx = i_load_byte;
    end else if (i_phase_edge) begin
      next_r.mosi = r.tx[7];
      next_r.tx = {r.tx[6:0], 1'b0};
    end
    if (i_sample_edge) begin
      next_r.rx = {r.rx[6:0], i_miso};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_mosi = r.mosi;
  assign o_rx_byte = r.rx;
endmodule
`default_nettype wire

/* File: design/host_port.sv */
`include "host_port_consts.svh"
`default_nettype none
module host_port #(
  parameter int ADDR_W = `HP_ADDR_W,
  parameter int DATA_W = `HP_DATA_W,
  parameter logic [9:0] SPI_BYTES = `HP_SPI_BYTES
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Mode pins
  input wire logic i_strap_config_select,
  input wire logic [1:0] i_host_interface_select,
  input wire logic i_spi_clock_phase_select,
  // Processor port
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_data,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe,
  // Register side
  input wire logic [DATA_W-1:0] i_reg_rdata,
  output logic [ADDR_W-1:0] o_reg_addr,
  output logic o_reg_rd,
  output logic o_reg_wr,
  output logic [DATA_W-1:0] o_reg_wdata,
  // Software line controls
  input wire host_port_pkg::line_cfg_s i_sw_cfg,
  // Effective line configuration
  output host_port_pkg::line_cfg_s o_line_cfg,
  // SPI master
  input wire logic i_spi_start,
  output logic o_spi_serial_clock,
  output logic o_spi_cs_n,
  output logic o_spi_mosi,
  output logic [7:0] o_spi_byte,
  output logic o_spi_byte_valid,
  output logic o_spi_busy
);
  import host_port_pkg::*;

  typedef struct packed {
    spi_state_e st;
    logic sck;
    logic [3:0] div;
    logic [3:0] bits;
    logic [9:0] bytes;
    logic cs_n;
    logic busy;
    logic bval;
    logic [7:0] rbyte;
    logic [DATA_W-1:0] dout;
    logic doe;
    logic [ADDR_W-1:0] raddr;
    logic rd;
    logic wr;
    logic wr_d;
    logic [DATA_W-1:0] wdata;
    line_cfg_s cfg;
  } state_s;

  state_s r;
  state_s next_r;
  logic tick;
  logic rise;
  logic fall;
  logic phase_edge;
  logic sample_edge;
  logic load;
  logic mosi;
  logic [7:0] rx_byte;
  logic sel_rw;
  logic sel_ds;
  logic reading;

  // ------------------------------------------------------------
  // Clock edges of the serial clock
  // ------------------------------------------------------------
  assign tick = (r.st == ST_SHIFT) && (r.div == `HP_SPI_DIV - 4'h1);
  assign rise = tick && !r.sck;
  assign fall = tick && r.sck;
  assign phase_edge = i_spi_clock_phase_select ? rise : fall;
  assign sample_edge = i_spi_clock_phase_select ? fall : rise;
  assign load = (r.st == ST_IDLE) && i_spi_start && !i_strap_config_select
    && (i_host_interface_select == `HP_SEL_SPI);

  spi_shifter u_shift (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_phase_edge(phase_edge),
    .i_sample_edge(sample_edge),
    .i_load(load),
    .i_load_byte(`HP_SPI_INSTR),
    .i_miso(i_data[1]),
    .o_mosi(mosi),
    .o_rx_byte(rx_byte)
  );

  // Processor port strobes
  assign sel_rw = !i_strap_config_select
    && (i_host_interface_select == `HP_SEL_RW);
  assign sel_ds = !i_strap_config_select
    && (i_host_interface_select == `HP_SEL_DS);
  // Data strobe style: wr pin carries read/write level
  assign reading = !i_cs_n && ((sel_rw && !i_rd_n)
    || (sel_ds && !i_rd_n && i_wr_n));

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.bval = 1'b0;
    next_r.rd = 1'b0;
    next_r.wr = 1'b0;
    // Address pins only feed the straps in hardware mode
    next_r.raddr = i_strap_config_select ? r.raddr : i_addr;
    next_r.doe = reading;
    next_r.dout = i_reg_rdata;
    next_r.rd = reading;
    next_r.wr_d = !i_cs_n && !i_wr_n && sel_rw
      || !i_cs_n && !i_rd_n && !i_wr_n && sel_ds;
    if (r.wr_d && !next_r.wr_d && !i_cs_n) begin
      next_r.wr = 1'b1;
    end
    next_r.wdata = i_data;
    if (i_strap_config_select) begin
      next_r.cfg.bit_order_lsb = i_addr[`HP_BIT_ORDER];
      next_r.cfg.scrambler_off = i_addr[`HP_SCRAMBLE_DIS];
      next_r.cfg.laps_encap = i_addr[`HP_ENCAP];
    end else begin
      next_r.cfg = i_sw_cfg;
    end
    case (r.st)
      ST_IDLE: begin
        next_r.sck = !i_spi_clock_phase_select;
        if (load) begin
          next_r.st = ST_SHIFT;
          next_r.cs_n = 1'b0;
          next_r.div = 4'h0;
          next_r.bits = 4'h0;
          next_r.bytes = 10'h000;
        end
      end
      ST_SHIFT: begin
        next_r.div = tick ? 4'h0 : r.div + 4'h1;
        if (tick) begin
          next_r.sck = !r.sck;
        end
        if (sample_edge) begin
          if (r.bits == 4'h7) begin
            next_r.bits = 4'h0;
            if (r.bytes != 10'h000) begin
              next_r.bval = 1'b1;
              next_r.rbyte = {rx_byte[6:0], i_data[1]};
            end
            next_r.bytes = r.bytes + 10'h001;
            if (r.bytes == SPI_BYTES) begin
              next_r.st = ST_DONE;
            end
          end else begin
            next_r.bits = r.bits + 4'h1;
          end
        end
      end
      ST_DONE: begin
        next_r.cs_n = 1'b1;
        next_r.st = ST_IDLE;
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase
    // Registered so the busy port never glitches
    next_r.busy = (next_r.st != ST_IDLE);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
      r.cs_n <= 1'b1;
      r.st <= ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign o_data = r.dout;
  assign o_data_oe = r.doe;
  assign o_reg_addr = r.raddr;
  assign o_reg_rd = r.rd;
  assign o_reg_wr = r.wr;
  assign o_reg_wdata = r.wdata;
  assign o_line_cfg = r.cfg;
  assign o_spi_serial_clock = r.sck;
  assign o_spi_cs_n = r.cs_n;
  assign o_spi_mosi = mosi;
  assign o_spi_byte = r.rbyte;
  assign o_spi_byte_valid = r.bval;
  assign o_spi_busy = r.busy;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_oe_off;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      $past(i_cs_n) |-> !o_data_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus driven");
  property p_strap_order;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_strap_config_select |=> o_line_cfg.bit_order_lsb == $past(i_addr[0]);
  endproperty
  a_strap_order: assert property (p_strap_order)
    else $error("bit order strap");
  property p_strap_scr;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_strap_config_select |=> o_line_cfg.scrambler_off == $past(i_addr[1]);
  endproperty
  a_strap_scr: assert property (p_strap_scr)
    else $error("scrambler strap");
  property p_strap_enc;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_strap_config_select |=> o_line_cfg.laps_encap == $past(i_addr[2]);
  endproperty
  a_strap_enc: assert property (p_strap_enc)
    else $error("encap strap");
  property p_sw_cfg;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      !i_strap_config_select |=> o_line_cfg == $past(i_sw_cfg);
  endproperty
  a_sw_cfg: assert property (p_sw_cfg) else $error("soft cfg");
  property p_mosi_edge;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      $changed(o_spi_mosi) |-> (i_spi_clock_phase_select
        ? $rose(o_spi_serial_clock) : $fell(o_spi_serial_clock));
  endproperty
  a_mosi_edge: assert property (p_mosi_edge) else $error("mosi edge");
  property p_sample_edge;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      sample_edge |=> (i_spi_clock_phase_select
        ? $fell(o_spi_serial_clock) : $rose(o_spi_serial_clock));
  endproperty
  a_sample_edge: assert property (p_sample_edge)
    else $error("sample edge");
  property p_hw_addr;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_strap_config_select |=> $stable(o_reg_addr) && !o_data_oe;
  endproperty
  a_hw_addr: assert property (p_hw_addr) else $error("addr used");
  property p_rsv;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_host_interface_select == `HP_SEL_RSV) |=> !o_reg_rd && !o_reg_wr;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved select");
endmodule
`default_nettype wire

/* File: verification/spi_eeprom_model.sv */
`default_nettype none
module spi_eeprom_model (
  // Serial bus
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_phase,
  input wire logic i_mosi,
  // Observation
  output logic o_miso,
  output logic [7:0] o_instr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // Behaviour
  // ----------
  logic [15:0] cnt = 16'h0000;
  logic [7:0] cur;
  wire logic launch = i_phase ? i_sck : ~i_sck;
  assign cur = 8'h5A + cnt[10:3];
  initial o_miso = 1'b0;
  initial o_instr = 8'h00;
  // Line toggles at deselect and through the instruction byte so stale bits never look valid
  always @(posedge launch or posedge i_cs_n) begin
    if (i_cs_n) begin
      cnt <= 16'h0000;
      o_miso <= ~o_miso;
    end else begin
      cnt <= cnt + 16'h0001;
      if (cnt < 16'h0008) o_miso <= ~o_miso;
      else o_miso <= cur[3'h7 - cnt[2:0]];
    end
  end
  always @(negedge launch) begin
    if (!i_cs_n && cnt <= 16'h0008) o_instr <= {o_instr[6:0], i_mosi};
  end
endmodule
`default_nettype wire

/* File: verification/host_port_tb.sv */
`default_nettype none
module host_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import host_port_pkg::*;
  localparam logic [9:0] NB = 10'h002;
  logic clk = 1'b0, rst_n = 1'b0, strap = 1'b0, ph = 1'b0;
  logic cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, start = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [9:0] addr = 10'h000, raddr;
  logic [7:0] dbus = 8'h00, rdata = 8'hC3, dout, wdata, sbyte, instr;
  logic oe, rrd, rwr, sck, scs_n, mosi, sval, busy, miso;
  line_cfg_s sw = 3'h0, cfg;
  wire logic [7:0] din = (sel == 2'h2) ? {6'h00, miso, 1'b0} : dbus;
  int error_cnt = 0;
  int num_checks = 0;
  int k;
  always #5 clk = ~clk;
  host_port #(.SPI_BYTES(NB)) dut (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_strap_config_select(strap), .i_host_interface_select(sel),
    .i_spi_clock_phase_select(ph), .i_cs_n(cs_n), .i_rd_n(rd_n),
    .i_wr_n(wr_n), .i_addr(addr), .i_data(din), .o_data(dout),
    .o_data_oe(oe), .i_reg_rdata(rdata), .o_reg_addr(raddr),
    .o_reg_rd(rrd), .o_reg_wr(rwr), .o_reg_wdata(wdata), .i_sw_cfg(sw),
    .o_line_cfg(cfg), .i_spi_start(start), .o_spi_serial_clock(sck),
    .o_spi_cs_n(scs_n), .o_spi_mosi(mosi), .o_spi_byte(sbyte),
    .o_spi_byte_valid(sval), .o_spi_busy(busy));
  spi_eeprom_model eeprom (.i_sck(sck), .i_cs_n(scs_n), .i_phase(ph),
    .i_mosi(mosi), .o_miso(miso), .o_instr(instr));
  // ----------
  // Helpers
  // ----------
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Polls off the edge so a one-cycle pulse is never raced
  task automatic wait_val(ref logic s, input logic v);
    int i;
    #1;
    for (i = 0; i < 3000 && s !== v; i++) cyc(1);
    if (s !== v) begin
      error_cnt++;
      finish_test();
    end
  endtask
  task automatic bus_rd(logic [1:0] m, logic [9:0] a, logic exp_oe);
    @(posedge clk);
    sel <= m;
    addr <= a;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    wr_n <= 1'b1;
    cyc(2);
    check("read oe", oe, exp_oe);
    check("read strobe", rrd, exp_oe);
    if (exp_oe) begin
      check("read addr", raddr, a);
      check("read data", dout, rdata);
    end
    @(posedge clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    cyc(3);
    check("idle oe", oe, 1'b0);
    check("idle strobe", rrd, 1'b0);
  endtask
  task automatic bus_wr(logic [1:0] m, logic [9:0] a, logic [7:0] d);
    @(posedge clk);
    sel <= m;
    addr <= a;
    dbus <= d;
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    rd_n <= (m != 2'h1);
    cyc(2);
    @(posedge clk);
    rd_n <= 1'b1;
    wr_n <= (m == 2'h0);
    wait_val(rwr, 1'b1);
    check("write data", wdata, d);
    check("write addr", raddr, a);
    @(posedge clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
  endtask
  task automatic spi_run(logic p);
    int n;
    @(posedge clk);
    sel <= 2'h2;
    ph <= p;
    cyc(2);
    check("spi clock idle", sck, !p);
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (n = 1; n <= NB; n++) begin
      wait_val(sval, 1'b1);
      check("spi byte", sbyte, 8'h5A + n[7:0]);
      check("spi select", scs_n, 1'b0);
      check("spi busy", busy, 1'b1);
      cyc(1);
    end
    check("spi instr", instr, 8'h03);
    wait_val(busy, 1'b0);
    cyc(2);
    check("spi deselect", scs_n, 1'b1);
    check("spi clock rest", sck, !p);
  endtask
  // ----------
  // Sequence
  // ----------
  initial begin
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    cyc(3);
    check("reset oe", oe, 1'b0);
    check("reset spi select", scs_n, 1'b1);
    @(posedge clk);
    rst_n <= 1'b1;
    strap <= 1'b1;
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      addr <= {7'h2A, k[2:0]};
      sw <= ~k[2:0];
      cyc(2);
      check("strap cfg", cfg, {k[0], k[1], k[2]});
      check("strap oe", oe, 1'b0);
      check("strap addr", raddr, 10'h000);
    end
    @(posedge clk);
    strap <= 1'b0;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      sw <= k[2:0];
      addr <= {7'h00, ~k[2:0]};
      cyc(2);
      check("soft cfg", cfg, k[2:0]);
    end
    bus_rd(2'h0, 10'h200, 1'b1);
    bus_rd(2'h1, 10'h001, 1'b1);
    bus_rd(2'h3, 10'h155, 1'b0);
    bus_wr(2'h0, 10'h3FF, 8'h96);
    bus_wr(2'h1, 10'h0A5, 8'h69);
    spi_run(1'b1);
    spi_run(1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
